// *** design/scil_top.sv ***
// Command pulse decoding, deviation counter and sequence input routing with AXI4-Lite registers.
//
// How it works
// - Three pulse formats chosen by setup word two.
// - Pulses up to 200 kpps; faster flagged.
// - Clear input active zeroes counter, drops pulses.
// - Setup bit selects clear level or edge.
// - Speed mode off: shared inputs limit torque.
// - Speed mode on: inputs select internal speed.
// - Manual mode: servo energized only while run.
// - Auto mode: servo energized unless alarm, run ignored.
// - Mux input lowers gain when so configured.
// - Mux input blocks pulses when so configured.
// - Speed mode: mux input gives speed direction.
// - Forward overtravel inactive prohibits forward, maskable.
// - Reverse overtravel inactive prohibits reverse, maskable.
// - Alarm reset rising edge clears alarm.
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`include "scil_map.svh"
`timescale 1ns/1ns
module scil_top #(
   parameter int DEV_W = 16,
   parameter int SPEED_W = 16,
   parameter int FIFO_DEPTH = 2,
   parameter int SPACING_CYC = `SCIL_PULSE_SPACING_CYC
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Connector pins from the host controller.
   input wire logic feed_pulse_in,
   input wire logic forward_pulse_in,
   input wire logic deviation_clear_in,
   input wire logic forward_torque_limit_in,
   input wire logic reverse_torque_limit_in,
   input wire logic run_in,
   input wire logic gain_reduce_in,
   input wire logic forward_overtravel_in,
   input wire logic reverse_overtravel_in,
   input wire logic alarm_reset_in,
   // Internal protection and loop feedback.
   input wire logic alarm_event_in,
   input wire logic fb_step_valid,
   input wire logic fb_step_reverse,
   // Step stream towards the position loop.
   output logic cmd_step_valid,
   input wire logic cmd_step_ready,
   output logic cmd_step_reverse,
   // Routed sequence outputs.
   output logic servo_on,
   output logic alarm,
   output logic fwd_current_limit,
   output logic rev_current_limit,
   output logic gain_reduce,
   output logic fwd_prohibit,
   output logic rev_prohibit,
   output logic speed_reverse,
   output logic [SPEED_W-1:0] speed_ref,
   output logic [DEV_W-1:0] deviation
);

   // Setup and speed words written by software.
   logic [15:0] setup1_r;
   logic [15:0] setup2_r;
   logic [SPEED_W-1:0] speed1_r;
   logic [SPEED_W-1:0] speed2_r;
   logic [SPEED_W-1:0] speed3_r;

   // Block state.
   scil_pkg::scil_pins_t pins; // Synchronised pin levels.
   scil_pkg::scil_pins_t pins_d_r; // Pin levels one cycle earlier.
   logic [DEV_W-1:0] dev_r;
   logic servo_on_r, alarm_r, fwd_lim_r, rev_lim_r, gain_r, fwd_pro_r, rev_pro_r, sdir_r;
   logic [SPEED_W-1:0] speed_r;
   logic rate_fault_r; // Pulses arrived faster than the highest rate.
   logic overrun_r; // A step found the buffer full.
   logic [11:0] gap_r; // Cycles since the last pulse edge, saturating.

   // Synchronise every connector pin before use.
   scil_sync #(.W(10)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({feed_pulse_in, forward_pulse_in, deviation_clear_in, forward_torque_limit_in,
            reverse_torque_limit_in, run_in, gain_reduce_in, forward_overtravel_in,
            reverse_overtravel_in, alarm_reset_in}),
      .dout(pins)
   );

   // Keeps the previous levels for edge detection.
   always_ff @(posedge aclk) begin
      if (!aresetn) pins_d_r <= '0;
      else pins_d_r <= pins;
   end

   // Configuration decoding.
   wire auto_servo = setup1_r[`SCIL_S1_AUTO_SERVO];
   wire ign_fwd_ot = setup1_r[`SCIL_S1_IGNORE_FWD_OT];
   wire ign_rev_ot = setup1_r[`SCIL_S1_IGNORE_REV_OT];
   wire mux_block = setup1_r[`SCIL_S1_MUX_IS_BLOCK];
   wire speed_mode = setup2_r[`SCIL_S2_SPEED_MODE];
   wire clear_edge = setup2_r[`SCIL_S2_CLEAR_EDGE];
   wire [2:0] fmt = setup2_r[`SCIL_S2_FMT_HI:`SCIL_S2_FMT_LO];

   // Edge detection on synchronised levels.
   wire rise_a = pins.pulse_a && !pins_d_r.pulse_a;
   wire rise_b = pins.pulse_b && !pins_d_r.pulse_b;
   wire rise_clr = pins.dev_clear && !pins_d_r.dev_clear;
   wire rise_rst = pins.alarm_reset && !pins_d_r.alarm_reset;

   // Two-phase decoding with four counts per cycle; forward when phase A leads.
   function automatic scil_pkg::scil_step_t quad(input logic pa, input logic pb,
                                                 input logic ca, input logic cb);
      quad.valid = (pa ^ ca) ^ (pb ^ cb);
      quad.reverse = pa ^ cb;
   endfunction : quad

   // Format selection of the raw step.
   scil_pkg::scil_step_t step_raw;
   scil_pkg::scil_step_t step_quad;
   assign step_quad = quad(pins_d_r.pulse_a, pins_d_r.pulse_b, pins.pulse_a, pins.pulse_b);
   always_comb begin
      case (fmt)
         `SCIL_FMT_PULSE_DIR: begin
            step_raw.valid = rise_a;
            step_raw.reverse = pins.pulse_b;
         end
         `SCIL_FMT_TWO_PULSE: begin
            step_raw.valid = rise_a ^ rise_b;
            step_raw.reverse = rise_a;
         end
         default: begin
            step_raw = step_quad;
         end
      endcase
   end

   // Clear acts on the level or on its rising edge.
   wire clear_now = clear_edge ? rise_clr : pins.dev_clear;
   // Pulse blocking by the multiplexed input.
   wire pulse_block = !speed_mode && mux_block && pins.mux;
   // Pulses are dropped while cleared or blocked.
   wire step_take = step_raw.valid && !clear_now && !pulse_block;

   // Step buffer towards the position loop.
   logic fifo_ready;
   logic fifo_valid;
   logic fifo_data;
   wire push = step_take && fifo_ready;
   scil_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_valid(step_take),
      .s_ready(fifo_ready),
      .s_data(step_raw.reverse),
      .m_valid(fifo_valid),
      .m_ready(cmd_step_ready),
      .m_data(fifo_data)
   );

   // Deviation counter: commanded steps add, loop feedback steps subtract.
   wire [DEV_W-1:0] cmd_delta = !push ? '0 : (step_raw.reverse ? '1 : DEV_W'(1));
   wire [DEV_W-1:0] fb_delta = !fb_step_valid ? '0 : (fb_step_reverse ? '1 : DEV_W'(1));
   wire [DEV_W-1:0] dev_nxt = clear_now ? '0 : DEV_W'(dev_r + cmd_delta - fb_delta);

   // Pulse spacing check on the rising edges of either pulse pin, or of pulse A only in pulse/direction format.
   wire pulse_edge = (rise_a || rise_b) && (fmt == `SCIL_FMT_PULSE_DIR ? rise_a : 1'b1);
   wire too_fast = pulse_edge && (gap_r < 12'(SPACING_CYC));
   wire [11:0] gap_nxt = pulse_edge ? 12'h000 :
                         (gap_r == 12'hfff ? gap_r : 12'(gap_r + 1'b1));

   // Sequence routing.
   wire servo_nxt = (auto_servo || pins.run) && !alarm_r;
   wire fwd_lim_nxt = !speed_mode && pins.sel_a;
   wire rev_lim_nxt = !speed_mode && pins.sel_b;
   wire gain_nxt = !speed_mode && !mux_block && pins.mux;
   wire sdir_nxt = speed_mode && pins.mux;
   wire fwd_pro_nxt = !ign_fwd_ot && !pins.fwd_ot;
   wire rev_pro_nxt = !ign_rev_ot && !pins.rev_ot;
   wire [1:0] sel = {pins.sel_b, pins.sel_a};
   wire [SPEED_W-1:0] speed_nxt = !speed_mode ? '0 :
                                  (sel == 2'h1) ? speed1_r :
                                  (sel == 2'h2) ? speed2_r :
                                  (sel == 2'h3) ? speed3_r : '0;
   // The alarm is set by protection and cleared by the reset edge; a set wins.
   wire alarm_nxt = alarm_event_in || (alarm_r && !rise_rst);

   // AXI write and read handling.
   logic aw_held_r, w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   wire wr_go = aw_held_r && w_held_r && !bvalid_r;
   wire status_hit = (aw_addr_r == `SCIL_OFF_STATUS);
   wire wr_map = (aw_addr_r == `SCIL_OFF_SETUP1) || (aw_addr_r == `SCIL_OFF_SETUP2) ||
                 (aw_addr_r == `SCIL_OFF_SPEED1) || (aw_addr_r == `SCIL_OFF_SPEED2) ||
                 (aw_addr_r == `SCIL_OFF_SPEED3) || status_hit ||
                 (aw_addr_r == `SCIL_OFF_DEVIATION);
   wire [15:0] wlo = {w_strb_r[1] ? w_data_r[15:8] : 8'h00, w_strb_r[0] ? w_data_r[7:0] : 8'h00};
   wire clr_rate = wr_go && status_hit && wlo[`SCIL_ST_RATE_FAULT];
   wire clr_ovr = wr_go && status_hit && wlo[`SCIL_ST_OVERRUN];
   wire [31:0] status_word = {24'h000000, pulse_block, gain_r, overrun_r, rate_fault_r,
                              rev_pro_r, fwd_pro_r, alarm_r, servo_on_r};
   wire rd_go = s_axi_arvalid && !rvalid_r;

   // Merges a written word into a register under the byte strobes.
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
      merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   // Read data selection; unmapped offsets answer with an error and zero.
   logic [31:0] rd_word;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `SCIL_OFF_SETUP1: rd_word = {16'h0000, setup1_r};
         `SCIL_OFF_SETUP2: rd_word = {16'h0000, setup2_r};
         `SCIL_OFF_SPEED1: rd_word = 32'(speed1_r);
         `SCIL_OFF_SPEED2: rd_word = 32'(speed2_r);
         `SCIL_OFF_SPEED3: rd_word = 32'(speed3_r);
         `SCIL_OFF_STATUS: rd_word = status_word;
         `SCIL_OFF_DEVIATION: rd_word = 32'(dev_r);
         default: begin
            rd_word = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Address and data are held independently, then answered together.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `SCIL_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_r) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? `SCIL_RESP_OKAY : `SCIL_RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Writable registers; status accepts writes only as flag clears, deviation writes have no effect.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         setup1_r <= `SCIL_SETUP1_RST;
         setup2_r <= `SCIL_SETUP2_RST;
         speed1_r <= SPEED_W'(`SCIL_SPEED_RST);
         speed2_r <= SPEED_W'(`SCIL_SPEED_RST);
         speed3_r <= SPEED_W'(`SCIL_SPEED_RST);
      end else if (wr_go) begin
         if (aw_addr_r == `SCIL_OFF_SETUP1) setup1_r <= merge(setup1_r, w_data_r, w_strb_r);
         if (aw_addr_r == `SCIL_OFF_SETUP2) setup2_r <= merge(setup2_r, w_data_r, w_strb_r);
         if (aw_addr_r == `SCIL_OFF_SPEED1)
            speed1_r <= SPEED_W'(merge(16'(speed1_r), w_data_r, w_strb_r));
         if (aw_addr_r == `SCIL_OFF_SPEED2)
            speed2_r <= SPEED_W'(merge(16'(speed2_r), w_data_r, w_strb_r));
         if (aw_addr_r == `SCIL_OFF_SPEED3)
            speed3_r <= SPEED_W'(merge(16'(speed3_r), w_data_r, w_strb_r));
      end
   end

   // Read channel: one cycle from address to data.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `SCIL_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? `SCIL_RESP_OKAY : `SCIL_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Block state registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dev_r <= '0;
         gap_r <= 12'hfff;
         rate_fault_r <= 1'b0;
         overrun_r <= 1'b0;
         servo_on_r <= 1'b0;
         alarm_r <= 1'b0;
         fwd_lim_r <= 1'b0;
         rev_lim_r <= 1'b0;
         gain_r <= 1'b0;
         sdir_r <= 1'b0;
         fwd_pro_r <= 1'b0;
         rev_pro_r <= 1'b0;
         speed_r <= '0;
      end else begin
         dev_r <= dev_nxt;
         gap_r <= gap_nxt;
         rate_fault_r <= too_fast || (rate_fault_r && !clr_rate);
         overrun_r <= (step_take && !fifo_ready) || (overrun_r && !clr_ovr);
         servo_on_r <= servo_nxt;
         alarm_r <= alarm_nxt;
         fwd_lim_r <= fwd_lim_nxt;
         rev_lim_r <= rev_lim_nxt;
         gain_r <= gain_nxt;
         sdir_r <= sdir_nxt;
         fwd_pro_r <= fwd_pro_nxt;
         rev_pro_r <= rev_pro_nxt;
         speed_r <= speed_nxt;
      end
   end

   // Output ports.
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign cmd_step_valid = fifo_valid;
   assign cmd_step_reverse = fifo_data;
   assign servo_on = servo_on_r;
   assign alarm = alarm_r;
   assign fwd_current_limit = fwd_lim_r;
   assign rev_current_limit = rev_lim_r;
   assign gain_reduce = gain_r;
   assign fwd_prohibit = fwd_pro_r;
   assign rev_prohibit = rev_pro_r;
   assign speed_reverse = sdir_r;
   assign speed_ref = speed_r;
   assign deviation = dev_r;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_clear_rise;
      clear_edge && pins.dev_clear && !pins_d_r.dev_clear;
   endsequence

   property p_clear_level;
      !clear_edge && pins.dev_clear |=> dev_r == '0;
   endproperty
   a_clear_level: assert property (p_clear_level) else $error("Counter not held at zero.");

   property p_clear_edge;
      s_clear_rise ##0 !$past(pins.dev_clear, 1) |-> !push ##1 dev_r == '0;
   endproperty
   a_clear_edge: assert property (p_clear_edge) else $error("Edge clear failed.");

   property p_block;
      !speed_mode && mux_block && pins.mux |-> !push;
   endproperty
   a_block: assert property (p_block) else $error("Pulse passed while blocked.");

   property p_limits;
      speed_mode |=> !fwd_lim_r && !rev_lim_r;
   endproperty
   a_limits: assert property (p_limits) else $error("Limit active in speed mode.");

   property p_auto;
      auto_servo && !alarm_r && !alarm_event_in |=> servo_on_r [*2];
   endproperty
   a_auto: assert property (p_auto) else $error("Auto servo not on.");

   property p_manual;
      !auto_servo && !pins.run |=> !servo_on_r;
   endproperty
   a_manual: assert property (p_manual) else $error("Servo on without run.");

   property p_fwd_ot;
      !ign_fwd_ot && !pins.fwd_ot |=> fwd_pro_r;
   endproperty
   a_fwd_ot: assert property (p_fwd_ot) else $error("Forward not prohibited.");

   property p_rev_ot;
      ign_rev_ot |=> !rev_pro_r;
   endproperty
   a_rev_ot: assert property (p_rev_ot) else $error("Ignored reverse input used.");

   property p_alarm_clear;
      alarm_r && rise_rst && !alarm_event_in |=> !alarm_r;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) else $error("Alarm not cleared.");

   property p_speed_dir;
      speed_mode && pins.mux |=> sdir_r && !gain_r;
   endproperty
   a_speed_dir: assert property (p_speed_dir) else $error("Speed direction wrong.");

   property p_rate;
      too_fast |=> rate_fault_r && gap_r == 12'h000;
   endproperty
   a_rate: assert property (p_rate) else $error("Rate fault not raised.");

endmodule : scil_top

// *** design/scil_map.svh ***
// Register offsets, field positions, reset values and timing counts of the servo input block.
`ifndef SCIL_MAP_SVH
`define SCIL_MAP_SVH

// Register byte offsets on the AXI4-Lite slave.
`define SCIL_OFF_SETUP1 8'h00
`define SCIL_OFF_SETUP2 8'h04
`define SCIL_OFF_SPEED1 8'h08
`define SCIL_OFF_SPEED2 8'h0c
`define SCIL_OFF_SPEED3 8'h10
`define SCIL_OFF_STATUS 8'h14
`define SCIL_OFF_DEVIATION 8'h18

// Field positions in setup word one.
`define SCIL_S1_AUTO_SERVO 0
`define SCIL_S1_IGNORE_FWD_OT 2
`define SCIL_S1_IGNORE_REV_OT 3
`define SCIL_S1_MUX_IS_BLOCK 15

// Field positions in setup word two.
`define SCIL_S2_SPEED_MODE 2
`define SCIL_S2_FMT_LO 3
`define SCIL_S2_FMT_HI 5
`define SCIL_S2_CLEAR_EDGE 10

// Pulse format codes held in setup word two.
`define SCIL_FMT_PULSE_DIR 3'h0
`define SCIL_FMT_TWO_PULSE 3'h1

// Status register bit positions.
`define SCIL_ST_SERVO_ON 0
`define SCIL_ST_ALARM 1
`define SCIL_ST_FWD_PROHIBIT 2
`define SCIL_ST_REV_PROHIBIT 3
`define SCIL_ST_RATE_FAULT 4
`define SCIL_ST_OVERRUN 5
`define SCIL_ST_GAIN_REDUCE 6
`define SCIL_ST_PULSE_BLOCK 7

// Reset values of the writable words.
`define SCIL_SETUP1_RST 16'h0000
`define SCIL_SETUP2_RST 16'h0000
`define SCIL_SPEED_RST 16'h0000

// Timing: clock period, highest pulse rate and the least pulse spacing in cycles.
`define SCIL_CLK_NS 4
`define SCIL_MAX_RATE_KPPS 200
`define SCIL_PULSE_SPACING_NS (1000000 / `SCIL_MAX_RATE_KPPS)
`define SCIL_PULSE_SPACING_CYC ((`SCIL_PULSE_SPACING_NS + `SCIL_CLK_NS - 1) / `SCIL_CLK_NS)

// AXI response codes.
`define SCIL_RESP_OKAY 2'h0
`define SCIL_RESP_SLVERR 2'h2

`endif

// *** design/scil_pkg.sv ***
// Types shared by the servo command input block.
package scil_pkg;

   // Control pins of the connector after synchronisation.
   typedef struct packed {
      logic pulse_a;
      logic pulse_b;
      logic dev_clear;
      logic sel_a;
      logic sel_b;
      logic run;
      logic mux;
      logic fwd_ot;
      logic rev_ot;
      logic alarm_reset;
   } scil_pins_t;

   // One decoded command step: valid flag and direction (1 means reverse).
   typedef struct packed {
      logic valid;
      logic reverse;
   } scil_step_t;

   // States of the AXI write path.
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_RESP
   } scil_wr_state_t;

endpackage : scil_pkg

// *** design/scil_sync.sv ***
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module scil_sync #(
   parameter int W = 10
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Raw and filtered levels.
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] s1_r; // First stage, read only by the second.
   logic [W-1:0] s2_r; // Second stage.
   logic [W-1:0] s3_r; // Third stage.
   logic [W-1:0] out_r; // Accepted level.

   // Each bit takes the new level only when stages two and three match.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         out_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= (s2_r & ~(s2_r ^ s3_r)) | (out_r & (s2_r ^ s3_r));
      end
   end

   assign dout = out_r;

endmodule : scil_sync

// *** design/scil_fifo.sv ***
// Small buffer with valid and ready on both sides for decoded command steps.
`timescale 1ns/1ns
module scil_fifo #(
   parameter int W = 1,
   parameter int DEPTH = 2
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Filling side.
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [W-1:0] s_data,
   // Draining side.
   output logic m_valid,
   input wire logic m_ready,
   output logic [W-1:0] m_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_r [DEPTH]; // Storage words.
   logic [PW-1:0] wr_ptr_r; // Next slot to write.
   logic [PW-1:0] rd_ptr_r; // Oldest slot.
   logic [PW:0] count_r; // Number of held words.
   wire push = s_valid && s_ready;
   wire pop = m_valid && m_ready;

   // Advances a pointer with wrap at the depth.
   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : bump

   // Pointer and count update; push and pop may happen together.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) wr_ptr_r <= bump(wr_ptr_r);
         if (pop) rd_ptr_r <= bump(rd_ptr_r);
         count_r <= (PW+1)'(count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
      end
   end

   // Storage write.
   always_ff @(posedge aclk) begin
      if (push) mem_r[wr_ptr_r] <= s_data;
   end

   assign s_ready = (count_r != (PW+1)'(DEPTH));
   assign m_valid = (count_r != '0);
   assign m_data = mem_r[rd_ptr_r];

endmodule : scil_fifo

// *** verification/scil_host.sv ***
// Host controller model that issues spaced command pulses.
`timescale 1ns/1ns
module scil_host (
   // Clock and pulse request.
   input wire logic aclk,
   input wire logic fire,
   input wire logic dir,
   // Pulse pins.
   output logic pa,
   output logic pb
);
   logic [4:0] cnt_r = 5'h00; // Cycles left in the current pulse period.
   // A request is taken only once the last period has run out.
   always @(posedge aclk) begin
      if (fire && cnt_r == 5'h00) begin
         cnt_r <= 5'h14;
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end
   end
   assign pa = cnt_r > 5'h10; // High for four cycles.
   assign pb = dir; // Direction level stays steady.
endmodule : scil_host

// *** verification/scil_top_tb.sv ***
// Self-checking bench of the servo command input block.
`include "scil_map.svh"
`timescale 1ns/1ns
module scil_top_tb;
   // Bus master and pin drive.
   logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, dir = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, run_in = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic deviation_clear_in = 1'b0, forward_torque_limit_in = 1'b0, gain_reduce_in = 1'b0;
   logic forward_overtravel_in = 1'b1, alarm_reset_in = 1'b0, alarm_event_in = 1'b0;
   logic cmd_step_ready = 1'b1, feed_pulse_in, forward_pulse_in, cmd_step_valid;
   logic servo_on, alarm, fwd_current_limit, fwd_prohibit, speed_reverse, gain_reduce;
   logic [15:0] speed_ref, deviation, exp_dev;
   int n_mismatch = 0, checked = 0, cyc = 0;
   // Device with a short pulse spacing so the run stays brief.
   scil_top #(.SPACING_CYC(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .feed_pulse_in,
      .forward_pulse_in, .deviation_clear_in, .forward_torque_limit_in,
      .reverse_torque_limit_in(1'b0), .run_in, .gain_reduce_in, .forward_overtravel_in,
      .reverse_overtravel_in(1'b1), .alarm_reset_in, .alarm_event_in, .fb_step_valid(1'b0),
      .fb_step_reverse(1'b0), .cmd_step_valid, .cmd_step_ready, .cmd_step_reverse(),
      .servo_on, .alarm, .fwd_current_limit, .rev_current_limit(), .gain_reduce,
      .fwd_prohibit, .rev_prohibit(), .speed_reverse, .speed_ref, .deviation);
   scil_host host (.aclk, .fire, .dir, .pa(feed_pulse_in), .pb(forward_pulse_in));
   // Free-running clock.
   initial forever #2 aclk = ~aclk;
   // Counts a mismatch and checks one value.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits a number of clock edges.
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick
   // One register write; each channel is released at its own handshake.
   task wr(input logic [7:0] a, input logic [31:0] d);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
   endtask : wr
   // One register read.
   task rdw(input logic [7:0] a);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      {resp, rd} = {s_axi_rresp, s_axi_rdata};
   endtask : rdw
   // Asks the host for one pulse and lets it settle.
   task pulse;
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      tick(24);
   endtask : pulse
   // Reset value of setup word two and an unmapped offset.
   task t_regs;
      rdw(`SCIL_OFF_SETUP2);
      chk(rd, 32'h0);
      rdw(8'h40);
      chk(32'(resp), 32'(`SCIL_RESP_SLVERR));
   endtask : t_regs
   // Each pulse format with direction low: forward, reverse pulse, quadrature net zero.
   task t_fmt;
      for (int i = 0; i < 3; i++) begin
         wr(`SCIL_OFF_SETUP2, 32'(i) << 3);
         pulse();
         exp_dev = exp_dev + ((i == 0) ? 16'h0001 : (i == 1) ? 16'hffff : 16'h0000);
         chk(32'(deviation), 32'(exp_dev));
      end
   endtask : t_fmt
   // Receiver stalls, the buffer refuses, then drains.
   task t_buf;
      wr(`SCIL_OFF_SETUP2, 32'h0);
      cmd_step_ready <= 1'b0;
      repeat (3) pulse();
      chk(32'(cmd_step_valid), 1);
      rdw(`SCIL_OFF_STATUS);
      chk(32'(rd[`SCIL_ST_OVERRUN]), 1);
      cmd_step_ready <= 1'b1;
      tick(6);
      chk(32'(cmd_step_valid), 0);
   endtask : t_buf
   // Clear as a level, then as an edge.
   task t_clear;
      deviation_clear_in <= 1'b1;
      pulse();
      chk(32'(deviation), 0);
      wr(`SCIL_OFF_SETUP2, 32'h400);
      pulse();
      chk(32'(deviation), 1);
      gain_reduce_in <= 1'b1;
      wr(`SCIL_OFF_SETUP1, 32'h8000);
      pulse();
      chk(32'(deviation), 1);
      wr(`SCIL_OFF_SETUP1, 32'h0);
      deviation_clear_in <= 1'b0;
   endtask : t_clear
   // Shared inputs, run and overtravel routing.
   task t_seq;
      {forward_torque_limit_in, run_in, gain_reduce_in, forward_overtravel_in} <= 4'he;
      tick(8);
      chk(32'({fwd_current_limit, servo_on, fwd_prohibit}), 32'h7);
      chk(32'(gain_reduce), 1);
      wr(`SCIL_OFF_SPEED1, 32'h123);
      wr(`SCIL_OFF_SETUP2, 32'h4);
      wr(`SCIL_OFF_SETUP1, 32'h5);
      run_in <= 1'b0;
      tick(8);
      chk(32'(speed_ref), 32'h123);
      chk(32'({speed_reverse, servo_on, fwd_prohibit}), 32'h6);
      chk(32'(gain_reduce), 0);
   endtask : t_seq
   // Alarm raised and cleared by the reset pin.
   task t_alarm;
      alarm_event_in <= 1'b1;
      tick(1);
      alarm_event_in <= 1'b0;
      tick(1);
      chk(32'(alarm), 1);
      alarm_reset_in <= 1'b1;
      tick(8);
      chk(32'(alarm), 0);
   endtask : t_alarm
   // Prints the counts and the verdict.
   task results;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   // Cuts a hang short.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         results();
      end
   end
   // Main sequence.
   initial begin
      exp_dev = 16'h0;
      tick(6);
      aresetn <= 1'b1;
      tick(1);
      t_regs();
      t_fmt();
      t_buf();
      t_clear();
      t_seq();
      t_alarm();
      results();
   end
endmodule : scil_top_tb
